// [include/amap_pkg.sv]
// Address map constants and types for the system address decoder
`default_nettype none

package amap_pkg;

  // Eight 512 MB blocks picked by the top three address bits
  localparam int         REGION_LSB    = 29;
  localparam logic [2:0] REGION_CODE   = 3'h0;
  localparam logic [2:0] REGION_SRAM   = 3'h1;
  localparam logic [2:0] REGION_PERIPH = 3'h2;

  // Window sizes as the lowest address bit that must match
  localparam int ALIAS_LSB = 14;
  localparam int SRAM_LSB  = 11;
  localparam int WIN_LSB   = 10;
  localparam int OPT_LSB   = 9;

  localparam logic [31:0] ALIAS_MASK = 32'h0000_3fff;
  localparam logic [31:0] SRAM_MASK  = 32'h0000_07ff;
  localparam logic [31:0] WIN_MASK   = 32'h0000_03ff;

  // Memory bases
  localparam logic [31:0] ALIAS_BASE  = 32'h0000_0000;
  localparam logic [31:0] FLASH_BASE  = 32'h0800_0000;
  localparam logic [31:0] SYSMEM_BASE = 32'h1fff_f400;
  localparam logic [31:0] OPT_BASE    = 32'h1fff_f800;
  localparam logic [31:0] SRAM_BASE   = 32'h2000_0000;

  // Boot mapping codes
  localparam logic [1:0] BOOT_MAIN   = 2'h0;
  localparam logic [1:0] BOOT_SYSMEM = 2'h1;
  localparam logic [1:0] BOOT_SRAM   = 2'h2;

  // Bus encodings
  localparam int         TRANS_ACTIVE_BIT = 1;
  localparam logic [2:0] SIZE_BYTE        = 3'h0;
  localparam logic [2:0] SIZE_HALF        = 3'h1;

  // High-speed bus targets outside the decoder
  localparam int N_AHB    = 8;
  localparam int T_FLASH  = 0;
  localparam int T_SYSMEM = 1;
  localparam int T_OPT    = 2;
  localparam int T_FREG   = 3;
  localparam int T_PORT_B = 7;

  // 1 KB high-speed windows, targets T_FREG upward in this order
  localparam int          N_AHB_WIN     = 5;
  localparam int          AHB_WIN_FIRST = 3;
  localparam logic [31:0] AHB_WIN_BASE [N_AHB_WIN] = '{
    32'h4002_2000,  // flash interface registers
    32'h4002_1000,  // reset_clock_controller
    32'h4002_3000,  // checksum unit
    32'h4800_0000,  // port A
    32'h4800_0400   // port B
  };

  // 1 KB bridged windows, psel bit order
  localparam int          N_APB = 13;
  localparam logic [31:0] APB_BASE [N_APB] = '{
    32'h4000_0400,  // general_timer_three
    32'h4000_3000,  // independent_watchdog
    32'h4000_4400,  // second_serial_port
    32'h4000_5400,  // two_wire_controller
    32'h4000_7000,  // power_controller
    32'h4001_0000,  // system_config
    32'h4001_0400,  // external_interrupt_unit
    32'h4001_2400,  // converter
    32'h4001_2c00,  // advanced_timer
    32'h4001_3000,  // serial_peripheral_port
    32'h4001_3400,  // debug_unit
    32'h4001_3800,  // first_serial_port
    32'h4001_4000   // timer_fourteen
  };

  // On-chip SRAM, 2 KB of words
  localparam int SRAM_AW = 9;

  typedef enum logic [2:0] {
    PH_IDLE, PH_SRAM, PH_AHB, PH_BR_CAP, PH_BR_SETUP, PH_BR_ACCESS, PH_ERR1, PH_ERR2
  } phase_type;

endpackage : amap_pkg

`default_nettype wire

// [rtl/word_store.sv]
// Byte-lane word memory with a registered read port
`timescale 1ns/1ps
`default_nettype none

module word_store #(
  parameter int AW = 9
) (
  // Clock
  input  wire logic          core_clk,
  input  wire logic          ce,
  // Write port
  input  wire logic          we,
  input  wire logic [3:0]    be,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [31:0]   wdata,
  // Read port
  input  wire logic          re,
  input  wire logic [AW-1:0] raddr,
  output logic      [31:0]   rdata
);

  logic [31:0] mem [0:(1<<AW)-1];

  // Read-first: a same-cycle write is merged by the caller
  always_ff @(posedge core_clk) begin
    if (ce) begin
      if (re) begin
        rdata <= mem[raddr];
      end
      for (int b = 0; b < 4; b++) begin
        if (we && be[b]) begin
          mem[waddr][b*8 +: 8] <= wdata[b*8 +: 8];
        end
      end
    end
  end

endmodule : word_store

`default_nettype wire

// [rtl/system_address_decoder.sv]
// Address decoder, SRAM port and peripheral bridge for the single-master bus
`timescale 1ns/1ps
`default_nettype none

module system_address_decoder (
  // Clock, reset, enable
  input  wire logic                         core_clk,
  input  wire logic                         arst_n,
  input  wire logic                         ce,
  // Boot mapping
  input  wire logic [1:0]                   boot_map,
  // Processor bus
  input  wire logic [31:0]                  haddr,
  input  wire logic [1:0]                   htrans,
  input  wire logic                         hwrite,
  input  wire logic [2:0]                   hsize,
  input  wire logic [31:0]                  hwdata,
  output logic                              hready,
  output logic                              hresp,
  output logic      [31:0]                  hrdata,
  // High-speed targets
  output logic      [amap_pkg::N_AHB-1:0]   tgt_hsel,
  output logic      [31:0]                  tgt_haddr,
  output logic      [1:0]                   tgt_htrans,
  output logic                              tgt_hwrite,
  output logic      [2:0]                   tgt_hsize,
  output logic      [31:0]                  tgt_hwdata,
  output logic                              tgt_hready,
  input  wire logic [amap_pkg::N_AHB-1:0]   tgt_hreadyout,
  input  wire logic [amap_pkg::N_AHB-1:0]   tgt_hresp,
  input  wire logic [amap_pkg::N_AHB-1:0][31:0] tgt_hrdata,
  // Bridged targets
  output logic      [amap_pkg::N_APB-1:0]   psel,
  output logic                              penable,
  output logic      [31:0]                  paddr,
  output logic                              pwrite,
  output logic      [31:0]                  pwdata,
  input  wire logic [amap_pkg::N_APB-1:0]   pready,
  input  wire logic [amap_pkg::N_APB-1:0]   pslverr,
  input  wire logic [amap_pkg::N_APB-1:0][31:0] prdata
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic                         acc;
  logic [31:0]                  eff_addr;
  logic                         dec_sram;
  logic [amap_pkg::N_AHB-1:0]   dec_ahb;
  logic [amap_pkg::N_APB-1:0]   dec_apb;
  logic [3:0]                   dec_idx;

  amap_pkg::phase_type          ph_reg;
  amap_pkg::phase_type          ph_next;
  logic [3:0]                   idx_reg;
  logic [3:0]                   idx_next;
  logic [31:0]                  addr_reg;
  logic [31:0]                  addr_next;
  logic                         write_reg;
  logic                         write_next;
  logic [2:0]                   size_reg;
  logic [2:0]                   size_next;
  logic [31:0]                  wdata_reg;
  logic [31:0]                  wdata_next;

  logic                         mem_re;
  logic                         mem_we;
  logic [3:0]                   mem_be;
  logic [amap_pkg::SRAM_AW-1:0] mem_raddr;
  logic [31:0]                  mem_rdata;
  logic [3:0]                   byp_be_reg;
  logic [3:0]                   byp_be_next;
  logic [31:0]                  byp_data_reg;
  logic [31:0]                  byp_data_next;
  logic [31:0]                  sram_rdata;

  function automatic logic [3:0] lane_mask(input logic [2:0] size, input logic [1:0] a);
    unique case (size)
      amap_pkg::SIZE_BYTE: lane_mask = 4'h1 << a;
      amap_pkg::SIZE_HALF: lane_mask = a[1] ? 4'hc : 4'h3;
      default:             lane_mask = 4'hf;
    endcase
  endfunction : lane_mask

  ////////////////////////////////////////////////////////////////////////////////
  // Address phase decode

  assign acc = ce && htrans[amap_pkg::TRANS_ACTIVE_BIT] && hready;

  always_comb begin
    dec_sram = 1'b0;
    dec_ahb  = '0;
    dec_apb  = '0;
    dec_idx  = 4'h0;
    eff_addr = haddr;
    unique case (haddr[31:amap_pkg::REGION_LSB])
      amap_pkg::REGION_CODE: begin
        if (haddr[31:amap_pkg::ALIAS_LSB] == amap_pkg::ALIAS_BASE[31:amap_pkg::ALIAS_LSB]) begin
          unique case (boot_map)
            amap_pkg::BOOT_SYSMEM: begin
              // Only the first 1 KB of the alias has memory behind it
              if (haddr[amap_pkg::ALIAS_LSB-1:amap_pkg::WIN_LSB] == '0) begin
                dec_ahb[amap_pkg::T_SYSMEM] = 1'b1;
                dec_idx  = 4'(amap_pkg::T_SYSMEM);
                eff_addr = amap_pkg::SYSMEM_BASE | (haddr & amap_pkg::WIN_MASK);
              end
            end
            amap_pkg::BOOT_SRAM: begin
              if (haddr[amap_pkg::ALIAS_LSB-1:amap_pkg::SRAM_LSB] == '0) begin
                dec_sram = 1'b1;
                eff_addr = amap_pkg::SRAM_BASE | (haddr & amap_pkg::SRAM_MASK);
              end
            end
            default: begin
              dec_ahb[amap_pkg::T_FLASH] = 1'b1;
              dec_idx  = 4'(amap_pkg::T_FLASH);
              eff_addr = amap_pkg::FLASH_BASE | (haddr & amap_pkg::ALIAS_MASK);
            end
          endcase
        end else if (haddr[31:amap_pkg::ALIAS_LSB] == amap_pkg::FLASH_BASE[31:amap_pkg::ALIAS_LSB]) begin
          dec_ahb[amap_pkg::T_FLASH] = 1'b1;
          dec_idx = 4'(amap_pkg::T_FLASH);
        end else if (haddr[31:amap_pkg::WIN_LSB] == amap_pkg::SYSMEM_BASE[31:amap_pkg::WIN_LSB]) begin
          dec_ahb[amap_pkg::T_SYSMEM] = 1'b1;
          dec_idx = 4'(amap_pkg::T_SYSMEM);
        end else if (haddr[31:amap_pkg::OPT_LSB] == amap_pkg::OPT_BASE[31:amap_pkg::OPT_LSB]) begin
          dec_ahb[amap_pkg::T_OPT] = 1'b1;
          dec_idx = 4'(amap_pkg::T_OPT);
        end
      end
      amap_pkg::REGION_SRAM: begin
        dec_sram = haddr[31:amap_pkg::SRAM_LSB] == amap_pkg::SRAM_BASE[31:amap_pkg::SRAM_LSB];
      end
      amap_pkg::REGION_PERIPH: begin
        for (int i = 0; i < amap_pkg::N_AHB_WIN; i++) begin
          if (haddr[31:amap_pkg::WIN_LSB] == amap_pkg::AHB_WIN_BASE[i][31:amap_pkg::WIN_LSB]) begin
            dec_ahb[amap_pkg::AHB_WIN_FIRST+i] = 1'b1;
            dec_idx = 4'(amap_pkg::AHB_WIN_FIRST + i);
          end
        end
        for (int i = 0; i < amap_pkg::N_APB; i++) begin
          if (haddr[31:amap_pkg::WIN_LSB] == amap_pkg::APB_BASE[i][31:amap_pkg::WIN_LSB]) begin
            dec_apb[i] = 1'b1;
            dec_idx = 4'(i);
          end
        end
      end
      default: begin
        // Upper blocks hold nothing; falls through to the error path
      end
    endcase
  end

  // Address phase forwarded unchanged except for the alias rebase
  assign tgt_hsel   = dec_ahb;
  assign tgt_haddr  = eff_addr;
  assign tgt_htrans = htrans;
  assign tgt_hwrite = hwrite;
  assign tgt_hsize  = hsize;
  assign tgt_hwdata = hwdata;
  assign tgt_hready = hready;

  ////////////////////////////////////////////////////////////////////////////////
  // Data phase answer

  always_comb begin
    hready = 1'b1;
    hresp  = 1'b0;
    hrdata = '0;
    unique case (ph_reg)
      amap_pkg::PH_IDLE: begin
      end
      amap_pkg::PH_SRAM: begin
        hrdata = sram_rdata;
      end
      amap_pkg::PH_AHB: begin
        hready = tgt_hreadyout[idx_reg[2:0]];
        hresp  = tgt_hresp[idx_reg[2:0]];
        hrdata = tgt_hrdata[idx_reg[2:0]];
      end
      amap_pkg::PH_BR_CAP, amap_pkg::PH_BR_SETUP: begin
        hready = 1'b0;
      end
      amap_pkg::PH_BR_ACCESS: begin
        hready = pready[idx_reg] && !pslverr[idx_reg];
        hrdata = prdata[idx_reg];
      end
      amap_pkg::PH_ERR1: begin
        hready = 1'b0;
        hresp  = 1'b1;
      end
      amap_pkg::PH_ERR2: begin
        hresp  = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Phase tracking and bridge

  always_comb begin
    ph_next    = ph_reg;
    idx_next   = idx_reg;
    addr_next  = addr_reg;
    write_next = write_reg;
    size_next  = size_reg;
    wdata_next = wdata_reg;
    unique case (ph_reg)
      amap_pkg::PH_BR_CAP: begin
        ph_next = amap_pkg::PH_BR_SETUP;
        // Narrow data copied to every lane: the bridged side has no strobes
        unique case (size_reg)
          amap_pkg::SIZE_BYTE: wdata_next = {4{hwdata[{addr_reg[1:0], 3'b000} +: 8]}};
          amap_pkg::SIZE_HALF: wdata_next = {2{hwdata[{addr_reg[1], 4'b0000} +: 16]}};
          default:             wdata_next = hwdata;
        endcase
      end
      amap_pkg::PH_BR_SETUP: begin
        ph_next = amap_pkg::PH_BR_ACCESS;
      end
      amap_pkg::PH_BR_ACCESS: begin
        if (pready[idx_reg] && pslverr[idx_reg]) begin
          ph_next = amap_pkg::PH_ERR1;
        end
      end
      amap_pkg::PH_ERR1: begin
        ph_next = amap_pkg::PH_ERR2;
      end
      default: begin
      end
    endcase
    if (hready) begin
      ph_next = amap_pkg::PH_IDLE;
      if (acc) begin
        addr_next  = eff_addr;
        write_next = hwrite;
        size_next  = hsize;
        idx_next   = dec_idx;
        if (dec_sram) begin
          ph_next = amap_pkg::PH_SRAM;
        end else if (|dec_ahb) begin
          ph_next = amap_pkg::PH_AHB;
        end else if (|dec_apb) begin
          ph_next = amap_pkg::PH_BR_CAP;
        end else begin
          ph_next = amap_pkg::PH_ERR1;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ph_reg    <= amap_pkg::PH_IDLE;
      idx_reg   <= 4'h0;
      addr_reg  <= 32'h0000_0000;
      write_reg <= 1'b0;
      size_reg  <= 3'h0;
      wdata_reg <= 32'h0000_0000;
    end else if (ce) begin
      ph_reg    <= ph_next;
      idx_reg   <= idx_next;
      addr_reg  <= addr_next;
      write_reg <= write_next;
      size_reg  <= size_next;
      wdata_reg <= wdata_next;
    end
  end

  assign psel    = (ph_reg == amap_pkg::PH_BR_SETUP || ph_reg == amap_pkg::PH_BR_ACCESS) ?
                   13'h0001 << idx_reg : 13'h0000;
  assign penable = ph_reg == amap_pkg::PH_BR_ACCESS;
  assign paddr   = {addr_reg[31:2], 2'b00};
  assign pwrite  = write_reg;
  assign pwdata  = wdata_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // SRAM port

  assign mem_re    = acc && dec_sram && !hwrite;
  assign mem_raddr = eff_addr[amap_pkg::SRAM_LSB-1:2];
  assign mem_we    = ce && ph_reg == amap_pkg::PH_SRAM && write_reg;
  assign mem_be    = lane_mask(size_reg, addr_reg[1:0]);

  // Read racing a write to the same word would see stale lanes
  always_comb begin
    byp_be_next   = byp_be_reg;
    byp_data_next = byp_data_reg;
    if (mem_re) begin
      byp_be_next   = (mem_we && addr_reg[amap_pkg::SRAM_LSB-1:2] == mem_raddr) ? mem_be : 4'h0;
      byp_data_next = hwdata;
    end
    for (int b = 0; b < 4; b++) begin
      sram_rdata[b*8 +: 8] = byp_be_reg[b] ? byp_data_reg[b*8 +: 8] : mem_rdata[b*8 +: 8];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      byp_be_reg   <= 4'h0;
      byp_data_reg <= 32'h0000_0000;
    end else if (ce) begin
      byp_be_reg   <= byp_be_next;
      byp_data_reg <= byp_data_next;
    end
  end

  word_store #(
    .AW (amap_pkg::SRAM_AW)
  ) u_sram (
    .core_clk (core_clk),
    .ce       (ce),
    .we       (mem_we),
    .be       (mem_be),
    .waddr    (addr_reg[amap_pkg::SRAM_LSB-1:2]),
    .wdata    (hwdata),
    .re       (mem_re),
    .raddr    (mem_raddr),
    .rdata    (mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking dc @(posedge core_clk iff ce); endclocking
  default disable iff (!arst_n);

  a_one_path: assert property (acc |-> $onehot0({dec_sram, |dec_ahb, |dec_apb}))
    else $error("access decoded to more than one path");
  a_upper_blocks: assert property (acc && haddr[31:29] > 3'h2 |=> ph_reg == amap_pkg::PH_ERR1)
    else $error("upper block access not refused");
  a_boot_alias: assert property (acc && haddr[31:14] == '0 && boot_map == amap_pkg::BOOT_MAIN
    |-> tgt_hsel[amap_pkg::T_FLASH] && tgt_haddr == (amap_pkg::FLASH_BASE | haddr))
    else $error("alias not sent to main flash");
  a_flash_main: assert property (acc && haddr[31:14] == 18'h02000 |-> tgt_hsel == 8'h01)
    else $error("main flash window not selected");
  a_option_win: assert property (acc && haddr[31:9] == 23'h0ffffc |-> tgt_hsel == 8'h04)
    else $error("option window not selected");
  a_sram_top: assert property (acc && haddr[31:29] == 3'h1 && haddr[28:11] != '0
    |=> ph_reg == amap_pkg::PH_ERR1)
    else $error("reserved sram block accepted");
  a_sram_lanes: assert property (mem_we && size_reg == amap_pkg::SIZE_BYTE |-> $countones(mem_be) == 1)
    else $error("byte store touched several lanes");
  a_sram_no_wait: assert property (acc && dec_sram |=> hready && !hresp)
    else $error("sram access waited");
  a_ahb_path: assert property (acc && |dec_ahb |=> ph_reg == amap_pkg::PH_AHB && psel == '0)
    else $error("high-speed target went through bridge");
  a_apb_widen: assert property (|psel |-> paddr[1:0] == 2'b00)
    else $error("bridged address not word aligned");
  a_apb_first: assert property (acc && haddr[31:10] == 22'h100001
    |-> ##2 psel == 13'h0001 && !penable ##1 penable && psel == 13'h0001)
    else $error("first bridged window sequence wrong");
  a_apb_last: assert property (acc && haddr[31:10] == 22'h100050 |-> ##2 psel == 13'h1000)
    else $error("last bridged window not selected");
  a_flash_regs: assert property (acc && haddr[31:10] == 22'h100088 |-> tgt_hsel == 8'h08)
    else $error("flash register window not selected");
  a_port_b: assert property (acc && haddr[31:10] == 22'h120001 |-> tgt_hsel == 8'h80)
    else $error("port B window not selected");
  a_error_pair: assert property (ph_reg == amap_pkg::PH_ERR1 |-> hresp && !hready ##1 hresp && hready)
    else $error("error response not two cycles");

endmodule : system_address_decoder

`default_nettype wire

// [rtl/unused_placeholder_none.sv]
// Intentionally empty source unit
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [verification/bus_master_model.sv]
// Processor-side master model issuing one transfer at a time
`timescale 1ns/1ps
`default_nettype none

module bus_master_model (
  // Clock
  input  wire logic        core_clk,
  // Request
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata,
  // Answer
  input  wire logic        hready,
  input  wire logic        hresp,
  input  wire logic [31:0] hrdata
);

  initial begin
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sole master, never pipelined: simpler, still legal on the bus
  // Ready is looked at once inputs and logic have settled before the edge
  task automatic xfer(input logic [31:0] a, input logic w, input logic [2:0] s, input logic [31:0] wd,
                      output logic [31:0] rd, output logic rsp, output int waits);
    int n;
    waits = 0;
    rsp   = 1'b0;
    n     = 0;
    @(negedge core_clk);
    haddr  = a;
    htrans = 2'h2;
    hwrite = w;
    hsize  = s;
    #1;
    while (hready !== 1'b1 && n < 50) begin
      @(negedge core_clk);
      #1;
      n++;
    end
    @(posedge core_clk);
    // Address lines scrambled once released, data phase begins
    @(negedge core_clk);
    htrans = 2'h0;
    haddr  = ~a;
    hwdata = wd;
    #1;
    while (hready !== 1'b1 && n < 100) begin
      waits++;
      rsp = rsp | (hresp === 1'b1);
      @(negedge core_clk);
      #1;
      n++;
    end
    rd  = hrdata;
    rsp = rsp | (hresp === 1'b1);
    @(posedge core_clk);
    // Return off the edge so callers never race the design's flops
    @(negedge core_clk);
  endtask : xfer

endmodule : bus_master_model
`default_nettype wire

// [verification/system_address_decoder_tb_top.sv]
// Self-checking bench for the system address decoder
`timescale 1ns/1ps
`default_nettype none

module system_address_decoder_tb_top;

  typedef struct packed {
    logic [1:0]  bm;
    logic [31:0] addr;
    logic [7:0]  hsel;
    logic [12:0] psel;
    logic        err;
  } case_type;

  localparam int       N_ROWS = 34;
  localparam case_type ROWS [N_ROWS] = '{
    '{2'h0, 32'h0000_0000, 8'h01, 13'h0, 1'b0}, '{2'h1, 32'h0000_0000, 8'h02, 13'h0, 1'b0},
    '{2'h3, 32'h0000_0000, 8'h01, 13'h0, 1'b0}, '{2'h1, 32'h0000_0400, 8'h00, 13'h0, 1'b1},
    '{2'h0, 32'h0000_8000, 8'h00, 13'h0, 1'b1}, '{2'h0, 32'h0800_3ffc, 8'h01, 13'h0, 1'b0},
    '{2'h0, 32'h0800_4000, 8'h00, 13'h0, 1'b1}, '{2'h0, 32'h1fff_f7fc, 8'h02, 13'h0, 1'b0},
    '{2'h0, 32'h1fff_f800, 8'h04, 13'h0, 1'b0}, '{2'h0, 32'h1fff_fa00, 8'h00, 13'h0, 1'b1},
    '{2'h0, 32'h2000_0800, 8'h00, 13'h0, 1'b1}, '{2'h0, 32'h4002_2000, 8'h08, 13'h0, 1'b0},
    '{2'h0, 32'h4002_1000, 8'h10, 13'h0, 1'b0}, '{2'h0, 32'h4002_3000, 8'h20, 13'h0, 1'b0},
    '{2'h0, 32'h4800_0000, 8'h40, 13'h0, 1'b0}, '{2'h0, 32'h4800_07fc, 8'h80, 13'h0, 1'b0},
    '{2'h0, 32'h4002_0000, 8'h00, 13'h0, 1'b1}, '{2'h0, 32'h4000_0000, 8'h00, 13'h0, 1'b1},
    '{2'h0, 32'h6000_0000, 8'h00, 13'h0, 1'b1}, '{2'h0, 32'h4000_07fc, 8'h00, 13'h0001, 1'b0},
    '{2'h0, 32'h4000_3000, 8'h00, 13'h0002, 1'b0}, '{2'h0, 32'h4000_4400, 8'h00, 13'h0004, 1'b0},
    '{2'h0, 32'h4000_5400, 8'h00, 13'h0008, 1'b0}, '{2'h0, 32'h4000_7000, 8'h00, 13'h0010, 1'b0},
    '{2'h0, 32'h4001_0000, 8'h00, 13'h0020, 1'b0}, '{2'h0, 32'h4001_0400, 8'h00, 13'h0040, 1'b0},
    '{2'h0, 32'h4001_2400, 8'h00, 13'h0080, 1'b0}, '{2'h0, 32'h4001_2c00, 8'h00, 13'h0100, 1'b0},
    '{2'h0, 32'h4001_3000, 8'h00, 13'h0200, 1'b0}, '{2'h0, 32'h4001_3400, 8'h00, 13'h0400, 1'b0},
    '{2'h0, 32'h4001_3800, 8'h00, 13'h0800, 1'b0}, '{2'h0, 32'h4001_43fc, 8'h00, 13'h1000, 1'b0},
    '{2'h0, 32'h4001_2800, 8'h00, 13'h0, 1'b1}, '{2'h0, 32'h4001_3c00, 8'h00, 13'h0, 1'b1}
  };

  logic                         core_clk = 1'b0;
  logic                         arst_n   = 1'b0;
  logic [1:0]                   boot_map = 2'h0;
  logic [31:0]                  haddr, hwdata, hrdata, paddr, pwdata;
  logic [1:0]                   htrans;
  logic [2:0]                   hsize;
  logic                         hwrite, hready, hresp, penable, pwrite;
  logic [amap_pkg::N_AHB-1:0]   tgt_hsel, tgt_hreadyout, hsel_seen;
  logic [amap_pkg::N_AHB-1:0][31:0] tgt_hrdata;
  logic [amap_pkg::N_APB-1:0]   psel, pready, pslverr, psel_seen;
  logic [amap_pkg::N_APB-1:0][31:0] prdata;
  logic [31:0]                  paddr_cap, pwdata_cap, rd, tgt_haddr, haddr_seen;
  logic                         pwrite_cap, rsp;
  int                           ahb_cnt, apb_cnt, waits, err_count, tests_run;
  int                           ahb_wait = 0;
  int                           apb_wait = 0;

  always #5 core_clk = ~core_clk;

  //////////////////////////////////////////////////////////////////////////////
  // Far-side targets: answer data names the target, waits are adjustable
  always_comb for (int i = 0; i < amap_pkg::N_AHB; i++) tgt_hrdata[i] = 32'h1 << i;
  always_comb for (int i = 0; i < amap_pkg::N_APB; i++) prdata[i] = 32'h1 << i;
  assign tgt_hreadyout = {amap_pkg::N_AHB{ahb_cnt >= ahb_wait}};
  assign pready        = {amap_pkg::N_APB{apb_cnt >= apb_wait}};

  always @(posedge core_clk) begin
    ahb_cnt <= (hready === 1'b1) ? 0 : ahb_cnt + 1;
    apb_cnt <= (penable === 1'b1 && pready[0] !== 1'b1) ? apb_cnt + 1 : 0;
    if (htrans[1] && hready) begin
      hsel_seen  <= hsel_seen | tgt_hsel;
      haddr_seen <= tgt_haddr;
    end
    psel_seen <= psel_seen | psel;
    if (penable && |psel) begin
      paddr_cap  <= paddr;
      pwdata_cap <= pwdata;
      pwrite_cap <= pwrite;
    end
  end

  bus_master_model i_bus_master_model (
    .core_clk(core_clk), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hresp(hresp), .hrdata(hrdata)
  );

  system_address_decoder i_system_address_decoder (
    .core_clk(core_clk), .arst_n(arst_n), .ce(1'b1), .boot_map(boot_map),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hresp(hresp), .hrdata(hrdata),
    .tgt_hsel(tgt_hsel), .tgt_haddr(tgt_haddr), .tgt_htrans(), .tgt_hwrite(), .tgt_hsize(), .tgt_hwdata(),
    .tgt_hready(), .tgt_hreadyout(tgt_hreadyout), .tgt_hresp({amap_pkg::N_AHB{1'b0}}),
    .tgt_hrdata(tgt_hrdata), .psel(psel), .penable(penable), .paddr(paddr), .pwrite(pwrite),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata)
  );

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic go(input logic [31:0] a, input logic w, input logic [2:0] s, input logic [31:0] wd);
    @(negedge core_clk);
    hsel_seen = '0;
    psel_seen = '0;
    i_bus_master_model.xfer(a, w, s, wd, rd, rsp, waits);
  endtask : go

  // Whole run is a few hundred cycles; this bound is far beyond it
  initial begin
    #200000;
    err_count++;
    tally_and_finish();
  end

  initial begin
    case_type r;
    err_count = 0;
    tests_run = 0;
    pslverr   = '0;
    repeat (5) @(posedge core_clk);
    #1;
    check({hready, hresp, penable, 16'h0, psel}, 32'h8000_0000);
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    arst_n = 1'b1;
    for (int i = 0; i < N_ROWS; i++) begin
      r = ROWS[i];
      @(negedge core_clk);
      boot_map = r.bm;
      go(r.addr, 1'b0, 3'h2, 32'h0);
      check(hsel_seen, r.hsel);
      check(psel_seen, r.psel);
      check(rsp, r.err);
      if (r.err) check(waits, 1);
      else check(rd, {24'h0, r.hsel} | {19'h0, r.psel});
    end
    // Narrow stores touch only their own lanes, no wait states anywhere
    boot_map = 2'h0;
    go(32'h2000_0010, 1'b1, 3'h2, 32'h1122_3344);
    check(waits, 0);
    go(32'h2000_0011, 1'b1, 3'h0, 32'h0000_aa00);
    go(32'h2000_0012, 1'b1, 3'h1, 32'hbeef_0000);
    go(32'h2000_0010, 1'b0, 3'h2, 32'h0);
    check(rd, 32'hbeef_aa44);
    check(waits, 0);
    @(negedge core_clk);
    boot_map = 2'h2;
    go(32'h0000_0010, 1'b0, 3'h2, 32'h0);
    check(rd, 32'hbeef_aa44);
    check(hsel_seen, 32'h0);
    @(negedge core_clk);
    boot_map = 2'h1;
    go(32'h0000_0104, 1'b0, 3'h2, 32'h0);
    check(haddr_seen, 32'h1fff_f504);
    check(rd, 32'h2);
    // Bridged narrow writes go out word aligned with lanes replicated
    apb_wait = 3;
    go(32'h4001_3001, 1'b1, 3'h0, 32'h0000_5500);
    check(paddr_cap, 32'h4001_3000);
    check(pwdata_cap, 32'h5555_5555);
    check(pwrite_cap, 1'b1);
    check(waits, 5);
    go(32'h4000_0402, 1'b1, 3'h1, 32'h1234_0000);
    check(pwdata_cap, 32'h1234_1234);
    check(paddr_cap, 32'h4000_0400);
    apb_wait = 0;
    pslverr = '1;
    go(32'h4000_3000, 1'b0, 3'h2, 32'h0);
    check(rsp, 1'b1);
    pslverr = '0;
    // A stalling high-speed target holds the master off
    ahb_wait = 2;
    go(32'h4800_0000, 1'b0, 3'h2, 32'h0);
    check(waits, 2);
    check(rd, 32'h40);
    check(rsp, 1'b0);
    tally_and_finish();
  end

endmodule : system_address_decoder_tb_top
`default_nettype wire
